// file: verilog/interrupt_accept_sequence.sv
// interrupt acceptance, entry sequence and return for a 16-bit cpu core
// assumes the pipeline reports instruction boundaries and holds spec_req until accepted
`include "irq_consts.svh"

// Contract
// - enable flag gates maskables, resets to zero
// - source sets request, acceptance clears it
// - software may only clear request bits
// - three-bit level, zero disables source
// - accept needs enable, request, level above ipl
// - ipl seven blocks all maskable interrupts
// - enable, requests, levels, ipl written independently
// - ordinary instruction finishes, entry starts next cycle
// - string and mac instructions suspend for entry
// - first step reads info, clears request
// - save flags, clear enable, debug, stack-select unless software 32-63
// - push flags, pc; load level into ipl
// - eighteen to twenty cycles by alignment, bus
// - debug two extra, step or match one
// - boundary wait stays within thirty cycles
// - watchdog/nmi ipl seven, reset zero, else kept
// - first word pc high and flags, then pc low
// - even stack word writes, odd byte writes
// - software 32-63 use selected stack, else irq
// - return pops flags and program counter
// - each source owns request and level
// - enable and ipl live in flag register
module interrupt_accept_sequence
  import irq_pkg::*;
(
  input  wire logic                              core_clk,
  input  wire logic                              rstn,
  input  wire logic [`IRQ_NSRC-1:0]              src_req,
  input  wire logic                              ctl_wr_req_en,
  input  wire logic                              ctl_wr_lvl_en,
  input  wire logic [2:0]                        ctl_wr_idx,
  input  wire logic                              ctl_wr_req_bit,
  input  wire logic [`IRQ_LVL_W-1:0]             ctl_wr_level,
  input  wire logic                              flag_wr_en,
  input  wire logic [15:0]                       flag_wr_data,
  input  wire logic                              instr_done,
  input  wire logic                              instr_suspendable,
  input  wire logic                              spec_req,
  input  wire spec_kind_t                        spec_kind,
  input  wire logic [5:0]                        spec_num,
  input  wire logic                              vec_odd,
  input  wire logic                              bus_8bit,
  input  wire logic [15:0]                       irq_stack_pointer,
  input  wire logic [15:0]                       user_stack_pointer,
  input  wire logic [19:0]                       pc,
  input  wire logic                              return_from_irq_instr,
  input  wire logic [15:0]                       pop_word_hi,
  input  wire logic [15:0]                       pop_word_lo,
  output logic [`IRQ_NSRC-1:0]                   req_bits_r,
  output logic [`IRQ_NSRC*`IRQ_LVL_W-1:0]        level_bits_r,
  output logic [15:0]                            processor_flag_register_r,
  output logic                                   seq_busy_r,
  output logic                                   seq_done_r,
  output logic                                   intinfo_rd_r,
  output logic [19:0]                            intinfo_addr_r,
  output logic [5:0]                             irq_num_r,
  output logic [2:0]                             irq_level_r,
  output logic                                   suspend_r,
  output logic                                   stk_wr_r,
  output logic                                   stk_byte_r,
  output logic [15:0]                            stk_addr_r,
  output logic [15:0]                            stk_data_r,
  output logic [15:0]                            new_sp_r,
  output logic                                   new_sp_user_r,
  output logic [19:0]                            pc_ret_r,
  output logic                                   pc_ret_valid_r
);

  // ===================================================================
  // helpers
  function automatic logic [3:0] best_src(input logic [`IRQ_NSRC-1:0] req,
                                          input logic [`IRQ_NSRC*`IRQ_LVL_W-1:0] lvl,
                                          input logic [2:0] processor_priority_level);
    logic [2:0] best;
    logic       found;
    logic [2:0] idx;
    best  = processor_priority_level;
    found = 1'b0;
    idx   = 3'h0;
    // strict compare: level 0 never wins, ipl 7 blocks all; ties keep lower index
    for (int i = 0; i < `IRQ_NSRC; i++)
    begin
      if (req[i] && (lvl[i*3 +: 3] > best))
      begin
        best  = lvl[i*3 +: 3];
        found = 1'b1;
        idx   = i[2:0];
      end
    end
    return {found, idx};
  endfunction

  function automatic logic [4:0] seq_len(input logic bus8, input logic vodd, input logic sodd,
                                         input spec_kind_t kind, input logic spec);
    logic [4:0] base;
    logic [1:0] extra;
    base  = bus8 ? `SEQ_CYC_BUS8 : (`SEQ_CYC_BUS16 + {4'h0, vodd} + {4'h0, sodd});
    extra = 2'h0;
    if (spec && kind == SPEC_DBG)
      extra = `SEQ_EXTRA_DBG;
    else if (spec && (kind == SPEC_SSTEP || kind == SPEC_AMATCH))
      extra = `SEQ_EXTRA_STEP;
    return base + {3'h0, extra};
  endfunction

  function automatic logic is_user_swint(input spec_kind_t kind, input logic [5:0] num);
    return (kind == SPEC_SWINT) && (num >= `SWINT_LO) && (num <= `SWINT_HI);
  endfunction

  // ===================================================================
  // acceptance decision
  seq_state_t  state_r;
  logic [4:0]  cnt_r;
  logic [4:0]  len_r;
  logic [1:0]  step_r;
  logic        spec_acc_r;
  spec_kind_t  kind_r;
  logic [2:0]  idx_r;
  logic [2:0]  lvl_acc_r;
  logic        keep_u_r;
  logic [15:0] sp_r;
  logic [19:0] pc_hold_r;
  logic [15:0] flag_tmp_r;

  logic [3:0]  pick;
  logic        boundary;
  logic        take_spec;
  logic        take_mask;
  logic        accept;
  logic        use_user;
  logic [15:0] sel_sp;
  logic        idle;
  logic        seq_end;
  logic [15:0] word_hi;

  assign idle      = (state_r == ST_IDLE);
  assign boundary  = instr_done | instr_suspendable;
  assign pick      = best_src(req_bits_r, level_bits_r,
                              processor_flag_register_r[`FLG_IPL_LSB +: 3]);
  assign take_spec = idle & boundary & spec_req;
  assign take_mask = idle & boundary & ~spec_req & processor_flag_register_r[`FLG_I_BIT] & pick[3];
  assign accept    = take_spec | take_mask;
  assign use_user  = take_spec & is_user_swint(spec_kind, spec_num) &
                     processor_flag_register_r[`FLG_U_BIT];
  assign sel_sp    = use_user ? user_stack_pointer : irq_stack_pointer;
  assign seq_end   = (state_r == ST_WAIT) && (cnt_r == 5'h01);
  assign word_hi   = {flag_tmp_r[15:12], pc_hold_r[19:16], flag_tmp_r[7:0]};

  // ===================================================================
  // per-source control: request bits and levels, each its own store
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      req_bits_r <= '0;
    else
    begin
      for (int i = 0; i < `IRQ_NSRC; i++)
      begin
        // set beats any clear landing in the same cycle
        if (src_req[i])
          req_bits_r[i] <= 1'b1;
        else if (ctl_wr_req_en && ctl_wr_idx == i[2:0] && !ctl_wr_req_bit)
          req_bits_r[i] <= 1'b0;
        else if (state_r == ST_ACK && !spec_acc_r && idx_r == i[2:0])
          req_bits_r[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      level_bits_r <= '0;
    else if (ctl_wr_lvl_en)
      level_bits_r[ctl_wr_idx*3 +: 3] <= ctl_wr_level;
  end

  // ===================================================================
  // sequencer
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r    <= ST_IDLE;
      cnt_r      <= 5'h00;
      len_r      <= 5'h00;
      step_r     <= 2'h0;
      seq_busy_r <= 1'b0;
      seq_done_r <= 1'b0;
    end
    else
    begin
      seq_done_r <= seq_end;
      if (state_r != ST_IDLE)
        cnt_r <= cnt_r - 5'h01;
      case (state_r)
        ST_IDLE:
        begin
          if (accept)
          begin
            state_r    <= ST_ACK;
            len_r      <= seq_len(bus_8bit, vec_odd, sel_sp[0], spec_kind, take_spec);
            cnt_r      <= seq_len(bus_8bit, vec_odd, sel_sp[0], spec_kind, take_spec) - 5'h01;
            seq_busy_r <= 1'b1;
          end
        end
        ST_ACK:
          state_r <= ST_SAVE;
        ST_SAVE:
        begin
          state_r <= ST_PUSH;
          step_r  <= 2'h0;
        end
        ST_PUSH:
        begin
          step_r <= step_r + 2'h1;
          if (step_r == (stk_byte_r ? 2'h3 : 2'h1))
            state_r <= ST_WAIT;
        end
        ST_WAIT:
        begin
          // pad out to the full documented length
          if (cnt_r == 5'h00)
          begin
            state_r    <= ST_IDLE;
            seq_busy_r <= 1'b0;
          end
        end
        default:
        begin
          state_r    <= ST_IDLE;
          seq_busy_r <= 1'b0;
        end
      endcase
    end
  end

  // ===================================================================
  // capture of the accepted interrupt
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      spec_acc_r     <= 1'b0;
      kind_r         <= SPEC_OTHER;
      idx_r          <= 3'h0;
      lvl_acc_r      <= 3'h0;
      keep_u_r       <= 1'b0;
      sp_r           <= 16'h0000;
      pc_hold_r      <= 20'h00000;
      irq_num_r      <= 6'h00;
      irq_level_r    <= 3'h0;
      suspend_r      <= 1'b0;
      intinfo_rd_r   <= 1'b0;
      intinfo_addr_r <= 20'h00000;
      new_sp_user_r  <= 1'b0;
    end
    else
    begin
      suspend_r    <= accept & instr_suspendable & ~instr_done;
      intinfo_rd_r <= take_mask;
      if (accept)
      begin
        spec_acc_r     <= take_spec;
        kind_r         <= spec_kind;
        idx_r          <= pick[2:0];
        lvl_acc_r      <= level_bits_r[pick[2:0]*3 +: 3];
        keep_u_r       <= take_spec & is_user_swint(spec_kind, spec_num);
        sp_r           <= sel_sp;
        pc_hold_r      <= pc;
        irq_num_r      <= take_spec ? spec_num : (`IRQ_SRC_NUM0 + {3'h0, pick[2:0]});
        irq_level_r    <= take_spec ? 3'h0 : level_bits_r[pick[2:0]*3 +: 3];
        intinfo_addr_r <= `INTINFO_ADDR;
        new_sp_user_r  <= use_user;
      end
    end
  end

  // ===================================================================
  // flag register: sequence owns it while busy, cpu writes only when idle
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      processor_flag_register_r <= `FLG_RESET;
      flag_tmp_r                <= 16'h0000;
      pc_ret_r                  <= 20'h00000;
      pc_ret_valid_r            <= 1'b0;
    end
    else
    begin
      pc_ret_valid_r <= 1'b0;
      if (state_r == ST_SAVE)
      begin
        flag_tmp_r <= processor_flag_register_r;
        processor_flag_register_r[`FLG_I_BIT] <= 1'b0;
        processor_flag_register_r[`FLG_D_BIT] <= 1'b0;
        if (!keep_u_r)
          processor_flag_register_r[`FLG_U_BIT] <= 1'b0;
      end
      else if (seq_end)
      begin
        if (!spec_acc_r)
          processor_flag_register_r[`FLG_IPL_LSB +: 3] <= lvl_acc_r;
        else if (kind_r == SPEC_WDT || kind_r == SPEC_NMI)
          processor_flag_register_r[`FLG_IPL_LSB +: 3] <= `IPL_ALL_OFF;
        else if (kind_r == SPEC_RESET)
          processor_flag_register_r[`FLG_IPL_LSB +: 3] <= `IPL_RESET_VAL;
      end
      else if (idle && return_from_irq_instr)
      begin
        // bits 11:8 of the saved word carry pc, not flags
        processor_flag_register_r <= {pop_word_hi[15:12], 4'h0, pop_word_hi[7:0]};
        pc_ret_r                  <= {pop_word_hi[11:8], pop_word_lo};
        pc_ret_valid_r            <= 1'b1;
      end
      else if (idle && flag_wr_en)
        processor_flag_register_r <= flag_wr_data;
    end
  end

  // ===================================================================
  // stack writes: two words, or four bytes when the pointer is odd
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      stk_wr_r   <= 1'b0;
      stk_byte_r <= 1'b0;
      stk_addr_r <= 16'h0000;
      stk_data_r <= 16'h0000;
      new_sp_r   <= 16'h0000;
    end
    else
    begin
      stk_wr_r <= (state_r == ST_PUSH);
      if (state_r == ST_ACK)
        stk_byte_r <= sp_r[0];
      if (seq_end)
        new_sp_r <= sp_r - 16'h0004;
      if (state_r == ST_PUSH)
      begin
        if (!stk_byte_r)
        begin
          stk_addr_r <= sp_r - {13'h0000, step_r, 1'b0} - 16'h0002;
          stk_data_r <= (step_r == 2'h0) ? word_hi : pc_hold_r[15:0];
        end
        else
        begin
          stk_addr_r <= sp_r - {14'h0000, step_r} - 16'h0001;
          case (step_r)
            2'h0:    stk_data_r <= {8'h00, word_hi[15:8]};
            2'h1:    stk_data_r <= {8'h00, word_hi[7:0]};
            2'h2:    stk_data_r <= {8'h00, pc_hold_r[15:8]};
            default: stk_data_r <= {8'h00, pc_hold_r[7:0]};
          endcase
        end
      end
    end
  end

  // ===================================================================
  // checks
  logic [4:0] busy_cnt;
  logic [5:0] wait_cnt;

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      busy_cnt <= 5'h00;
      wait_cnt <= 6'h00;
    end
    else
    begin
      busy_cnt <= seq_busy_r ? busy_cnt + 5'h01 : 5'h00;
      wait_cnt <= (idle && !boundary && (spec_req || (processor_flag_register_r[`FLG_I_BIT] && pick[3])))
                  ? wait_cnt + 6'h01 : 6'h00;
    end
  end

  a_mask_needs_enable: assert property (@(posedge core_clk) disable iff (!rstn)
    take_mask |-> processor_flag_register_r[`FLG_I_BIT] && req_bits_r[pick[2:0]])
    else $error("maskable accepted without enable or request");
  a_start_next_cycle: assert property (@(posedge core_clk) disable iff (!rstn)
    take_mask |=> seq_busy_r && intinfo_rd_r && state_r == ST_ACK)
    else $error("entry did not start in the next cycle");
  a_seq_length_exact: assert property (@(posedge core_clk) disable iff (!rstn)
    $fell(seq_busy_r) |-> busy_cnt == len_r)
    else $error("entry sequence length wrong");
  a_req_cleared_ack: assert property (@(posedge core_clk) disable iff (!rstn)
    state_r == ST_ACK && !spec_acc_r && !src_req[idx_r] |=> !req_bits_r[idx_r])
    else $error("request bit not cleared after info read");
  a_flags_cleared: assert property (@(posedge core_clk) disable iff (!rstn)
    state_r == ST_SAVE |=> !processor_flag_register_r[`FLG_I_BIT] && !processor_flag_register_r[`FLG_D_BIT]
                           && (processor_flag_register_r[`FLG_U_BIT] == (keep_u_r & $past(processor_flag_register_r[`FLG_U_BIT]))))
    else $error("flags not cleared on entry");
  a_ipl_loaded_level: assert property (@(posedge core_clk) disable iff (!rstn)
    seq_done_r && !spec_acc_r |-> processor_flag_register_r[`FLG_IPL_LSB +: 3] == lvl_acc_r)
    else $error("ipl not loaded with accepted level");
  a_ipl_nmi_wdt: assert property (@(posedge core_clk) disable iff (!rstn)
    seq_done_r && spec_acc_r && (kind_r == SPEC_WDT || kind_r == SPEC_NMI)
    |-> processor_flag_register_r[`FLG_IPL_LSB +: 3] == `IPL_ALL_OFF)
    else $error("ipl not raised to seven");
  a_first_word_layout: assert property (@(posedge core_clk) disable iff (!rstn)
    $rose(stk_wr_r) && !stk_byte_r |-> stk_data_r == word_hi && stk_addr_r == sp_r - 16'h0002)
    else $error("first stacked word wrong");
  a_push_word_count: assert property (@(posedge core_clk) disable iff (!rstn)
    $rose(stk_wr_r) && !sp_r[0] |-> !stk_byte_r ##0 stk_wr_r[*2] ##1 !stk_wr_r)
    else $error("word stack write width or count wrong");
  a_push_byte_count: assert property (@(posedge core_clk) disable iff (!rstn)
    $rose(stk_wr_r) && sp_r[0] |-> stk_byte_r ##0 stk_wr_r[*4] ##1 !stk_wr_r)
    else $error("byte stack write width or count wrong");
  a_boundary_wait: assert property (@(posedge core_clk) disable iff (!rstn)
    wait_cnt <= `MAX_WAIT_CYC)
    else $error("instruction boundary wait exceeded limit");
  a_return_restore: assert property (@(posedge core_clk) disable iff (!rstn)
    idle && return_from_irq_instr |=> pc_ret_valid_r && pc_ret_r == {$past(pop_word_hi[11:8]), $past(pop_word_lo)})
    else $error("return did not restore pc");

  c_maskable_entry: cover property (@(posedge core_clk) disable iff (!rstn) take_mask ##1 seq_busy_r [*8]);
  c_odd_stack_entry: cover property (@(posedge core_clk) disable iff (!rstn) $rose(stk_wr_r) && stk_byte_r);
  c_suspended_entry: cover property (@(posedge core_clk) disable iff (!rstn) suspend_r);
  c_debug_entry: cover property (@(posedge core_clk) disable iff (!rstn) seq_done_r && kind_r == SPEC_DBG && spec_acc_r);

endmodule

// file: verilog/irq_consts.svh
// interrupt acceptance block: offsets, field positions, reset values, cycle counts
// assumes inclusion by bare name from the package and the design module
`ifndef IRQ_CONSTS_SVH
`define IRQ_CONSTS_SVH

// =====================================================================
// source table
`define IRQ_NSRC        8
`define IRQ_LVL_W       3
`define IRQ_SRC_NUM0    6'h0A
`define INTINFO_ADDR    20'h00000

// =====================================================================
// processor flag register layout
`define FLG_D_BIT       1
`define FLG_I_BIT       6
`define FLG_U_BIT       7
`define FLG_IPL_LSB     12
`define FLG_RESET       16'h0000
`define IPL_ALL_OFF     3'h7
`define IPL_RESET_VAL   3'h0

// =====================================================================
// software numbers that keep the stack-select flag
`define SWINT_LO        6'h20
`define SWINT_HI        6'h3F

// =====================================================================
// entry sequence timing, in core_clk cycles
`define SEQ_CYC_BUS16   5'h12
`define SEQ_CYC_BUS8    5'h14
`define SEQ_EXTRA_DBG   2'h2
`define SEQ_EXTRA_STEP  2'h1
`define MAX_WAIT_CYC    6'h1E

`endif

// file: verilog/irq_pkg.sv
// types shared by the interrupt acceptance block
// assumes irq_consts.svh is on the include path
package irq_pkg;
  `include "irq_consts.svh"

  typedef enum logic [2:0]
  {
    SPEC_OTHER  = 3'h0,
    SPEC_WDT    = 3'h1,
    SPEC_NMI    = 3'h2,
    SPEC_DBG    = 3'h3,
    SPEC_SSTEP  = 3'h4,
    SPEC_AMATCH = 3'h5,
    SPEC_RESET  = 3'h6,
    SPEC_SWINT  = 3'h7
  } spec_kind_t;

  // gray along idle -> ack -> save -> push -> wait
  typedef enum logic [2:0]
  {
    ST_IDLE  = 3'h0,
    ST_ACK   = 3'h1,
    ST_SAVE  = 3'h3,
    ST_PUSH  = 3'h2,
    ST_WAIT  = 3'h6
  } seq_state_t;
endpackage

// file: verif/pipe_model.sv
// pipeline model: reports instruction boundaries to the block
// assumes the bench raises run only while it wants boundaries
module pipe_model
(
  input  wire logic core_clk,
  input  wire logic rstn,
  input  wire logic run,
  output logic      instr_done
);
  timeunit 1ns;
  timeprecision 1ps;
  // =====================================================================
  // boundary pulse
  logic [1:0] cnt_r;
  // short instructions, so the wait stays far below thirty cycles
  always_ff @(negedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_r <= 2'h0;
      instr_done <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_r + 2'h1;
      instr_done <= run && cnt_r == 2'h3;
    end
  end
endmodule

// file: verif/tb_interrupt_accept_sequence.sv
// bench for the interrupt acceptance block
// assumes irq_pkg is compiled first; inputs change on the falling edge
module tb_interrupt_accept_sequence;
  import irq_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // =====================================================================
  // signals
  logic core_clk, rstn, run, ctl_wr_req_en, ctl_wr_lvl_en, ctl_wr_req_bit, flag_wr_en;
  logic instr_done, instr_suspendable, spec_req, vec_odd, bus_8bit, return_from_irq_instr;
  logic [7:0] src_req, req_bits_r;
  logic [2:0] ctl_wr_idx, ctl_wr_level, irq_level_r;
  logic [15:0] flag_wr_data, irq_stack_pointer, user_stack_pointer, pop_word_hi, pop_word_lo;
  spec_kind_t spec_kind;
  logic [5:0] spec_num, irq_num_r;
  logic [19:0] pc, intinfo_addr_r, pc_ret_r;
  logic [23:0] level_bits_r;
  logic [15:0] processor_flag_register_r, stk_addr_r, stk_data_r, new_sp_r, a0, d0;
  logic seq_busy_r, seq_done_r, intinfo_rd_r, suspend_r, stk_wr_r, stk_byte_r;
  logic new_sp_user_r, pc_ret_valid_r, ir0, su0, dn0, b0;
  int miscompares = 0;
  int n_tests = 0;
  interrupt_accept_sequence dut (.*);
  pipe_model pipe (.core_clk(core_clk), .rstn(rstn), .run(run), .instr_done(instr_done));
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // =====================================================================
  // helpers
  task automatic chk(string nm, logic [19:0] seen, logic [19:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic ctl(logic re, logic le, logic [2:0] i, logic b, logic [2:0] l);
    ctl_wr_req_en = re; ctl_wr_lvl_en = le; ctl_wr_idx = i; ctl_wr_req_bit = b; ctl_wr_level = l;
    @(negedge core_clk);
    ctl_wr_req_en = 1'b0; ctl_wr_lvl_en = 1'b0;
  endtask
  task automatic processor_flag_register(logic [15:0] v);
    flag_wr_en = 1'b1; flag_wr_data = v;
    @(negedge core_clk);
    flag_wr_en = 1'b0;
  endtask
  task automatic wait_n(int n);
    repeat (n) @(negedge core_clk);
  endtask
  // bounded wait for busy, then count busy cycles and stack writes
  task automatic run_entry(input logic r, output int len, output int nwr);
    int t;
    len = 0; nwr = 0; t = 0; run = r;
    ir0 = 1'b0;
    su0 = 1'b0;
    dn0 = 1'b0;
    b0 = 1'b0;
    while (seq_busy_r !== 1'b1 && t < 60)
    begin
      @(negedge core_clk);
      t++;
    end
    spec_req = 1'b0; run = 1'b0;
    while (seq_busy_r === 1'b1 && len < 40)
    begin
      // pulses of the first busy cycle, done of the last one
      if (len == 0)
      begin
        ir0 = intinfo_rd_r;
        su0 = suspend_r;
      end
      dn0 = seq_done_r;
      if (stk_wr_r === 1'b1 && nwr == 0)
      begin
        a0 = stk_addr_r; d0 = stk_data_r; b0 = stk_byte_r;
      end
      if (stk_wr_r === 1'b1) nwr++;
      len++;
      @(negedge core_clk);
    end
  endtask
  // =====================================================================
  // scenarios
  task automatic t_gate();
    ctl(1'b0, 1'b1, 3'h2, 1'b0, 3'h5);
    src_req = 8'h04;
    @(negedge core_clk);
    src_req = 8'h00;
    ctl(1'b1, 1'b0, 3'h3, 1'b1, 3'h0);
    chk("req3", req_bits_r[3], 1'b0);
    chk("lvl2", level_bits_r[8:6], 3'h5);
    chk("req2", req_bits_r[2], 1'b1);
    processor_flag_register(16'h0000); run = 1'b1; wait_n(12);
    chk("busy_i0", seq_busy_r, 1'b0);
    processor_flag_register(16'h5040); wait_n(12);
    chk("busy_eq", seq_busy_r, 1'b0);
    processor_flag_register(16'h7040); wait_n(12);
    chk("busy_ipl7", seq_busy_r, 1'b0);
    run = 1'b0;
    ctl(1'b1, 1'b0, 3'h2, 1'b0, 3'h0);
    chk("req2_clr", req_bits_r[2], 1'b0);
    $display("test gate done");
  endtask
  task automatic t_mask(logic [15:0] sp, logic b8, logic vo, int elen, int enwr);
    int len, nwr;
    logic byt;
    byt = sp[0];
    ctl(1'b0, 1'b1, 3'h2, 1'b0, 3'h5);
    src_req = 8'h04;
    @(negedge core_clk);
    src_req = 8'h00;
    irq_stack_pointer = sp; bus_8bit = b8; vec_odd = vo; pc = 20'hABCDE;
    // quiet gap between control rewrite and enable
    wait_n(2);
    processor_flag_register(16'h4040);
    run_entry(1'b1, len, nwr);
    chk("len", len, elen);
    chk("nwr", nwr, enwr);
    chk("addr", a0, sp - (byt ? 16'h1 : 16'h2));
    chk("data", byt ? d0[7:0] : d0, byt ? 16'h004A : 16'h4A40);
    chk("req_clr", req_bits_r[2], 1'b0);
    chk("flags", processor_flag_register_r, 16'h5000);
    chk("num", irq_num_r, `IRQ_SRC_NUM0 + 6'h2);
    chk("lvl", irq_level_r, 3'h5);
    chk("sp", new_sp_r, sp - 16'h4);
    chk("info", ir0, 1'b1);
    chk("iaddr", intinfo_addr_r, `INTINFO_ADDR);
    chk("byte", b0, byt);
    chk("done", dn0, 1'b1);
    $display("test mask done");
  endtask
  // accepted mid string instruction, no instruction end
  task automatic t_susp();
    int len, nwr;
    ctl(1'b0, 1'b1, 3'h5, 1'b0, 3'h2);
    src_req = 8'h20;
    @(negedge core_clk);
    src_req = 8'h00;
    irq_stack_pointer = 16'h0100;
    bus_8bit = 1'b0;
    vec_odd = 1'b0;
    instr_suspendable = 1'b1;
    processor_flag_register(16'h0040);
    run_entry(1'b0, len, nwr);
    instr_suspendable = 1'b0;
    chk("susp", su0, 1'b1);
    chk("sinfo", ir0, 1'b1);
    chk("snum", irq_num_r, `IRQ_SRC_NUM0 + 6'h5);
    chk("slvl", processor_flag_register_r[14:12], 3'h2);
    $display("test suspend done");
  endtask
  // software number with user stack selected keeps that stack
  task automatic t_swint();
    int len, nwr;
    processor_flag_register(16'h3080);
    spec_kind = SPEC_SWINT;
    spec_num = 6'h20;
    spec_req = 1'b1;
    run_entry(1'b1, len, nwr);
    chk("ulen", len, 18);
    chk("uuse", new_sp_user_r, 1'b1);
    chk("usp", new_sp_r, 16'h01FC);
    chk("uflg", processor_flag_register_r, 16'h3080);
    chk("unum", irq_num_r, 6'h20);
    $display("test swint done");
  endtask
  task automatic t_spec(spec_kind_t k, logic [2:0] eipl, int elen);
    int len, nwr;
    irq_stack_pointer = 16'h0100; bus_8bit = 1'b0; vec_odd = 1'b0;
    processor_flag_register(16'h3000);
    spec_kind = k; spec_num = 6'h00; spec_req = 1'b1;
    run_entry(1'b1, len, nwr);
    chk("slen", len, elen);
    chk("sinfo0", ir0, 1'b0);
    chk("sipl", processor_flag_register_r[14:12], eipl);
    $display("test special done");
  endtask
  task automatic t_ret();
    return_from_irq_instr = 1'b1; pop_word_hi = 16'h5A47; pop_word_lo = 16'h1234;
    @(negedge core_clk);
    return_from_irq_instr = 1'b0;
    chk("rvalid", pc_ret_valid_r, 1'b1);
    chk("rpc", pc_ret_r, 20'hA1234);
    chk("rflg", processor_flag_register_r, 16'h5047);
    $display("test return done");
  endtask
  // =====================================================================
  // closing
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    #200000;
    miscompares++;
    final_report();
  end
  initial
  begin
    rstn = 1'b0; run = 1'b0; src_req = 8'h00; ctl_wr_req_en = 1'b0; ctl_wr_lvl_en = 1'b0;
    ctl_wr_idx = 3'h0; ctl_wr_req_bit = 1'b0; ctl_wr_level = 3'h0; flag_wr_en = 1'b0;
    flag_wr_data = 16'h0000; instr_suspendable = 1'b0; spec_req = 1'b0; spec_kind = SPEC_OTHER;
    spec_num = 6'h00; vec_odd = 1'b0; bus_8bit = 1'b0; irq_stack_pointer = 16'h0100;
    user_stack_pointer = 16'h0200; pc = 20'h00000; return_from_irq_instr = 1'b0;
    pop_word_hi = 16'h0000; pop_word_lo = 16'h0000;
    repeat (20) @(posedge core_clk);
    @(negedge core_clk);
    rstn = 1'b1;
    @(negedge core_clk);
    chk("rst_flg", processor_flag_register_r, 16'h0000);
    t_gate();
    t_mask(16'h0100, 1'b0, 1'b0, 18, 2);
    t_mask(16'h0100, 1'b0, 1'b1, 19, 2);
    t_mask(16'h0101, 1'b0, 1'b0, 19, 4);
    t_mask(16'h0101, 1'b0, 1'b1, 20, 4);
    t_mask(16'h0100, 1'b1, 1'b0, 20, 2);
    t_susp();
    t_spec(SPEC_WDT, 3'h7, 18);
    t_spec(SPEC_NMI, 3'h7, 18);
    t_spec(SPEC_DBG, 3'h3, 20);
    t_spec(SPEC_SSTEP, 3'h3, 19);
    t_spec(SPEC_AMATCH, 3'h3, 19);
    t_spec(SPEC_RESET, 3'h0, 18);
    t_swint();
    t_ret();
    final_report();
  end
endmodule
